//--- inc/nmh_pkg.sv
// Package: register map, field layout and carrier types of the negative MAC unit
package nmh_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] NMH_OFF_SRC_A = 8'h00;
  localparam logic [7:0] NMH_OFF_SRC_B = 8'h04;
  localparam logic [7:0] NMH_OFF_DEST = 8'h08;
  localparam logic [7:0] NMH_OFF_CTRL = 8'h0C;
  localparam logic [7:0] NMH_OFF_EXC = 8'h10;
  localparam logic [7:0] NMH_OFF_COND = 8'h14;
  localparam logic [7:0] NMH_OFF_IRQ_STS = 8'h18;
  localparam logic [7:0] NMH_OFF_IRQ_MSK = 8'h1C;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int NMH_CTRL_GO = 0;
  localparam int NMH_CTRL_HIGH = 1;
  localparam int NMH_CTRL_SAT = 2;
  localparam int NMH_CTRL_REC = 3;
  localparam int NMH_CTRL_OE = 4;
  localparam int NMH_EXC_SO = 31;
  localparam int NMH_EXC_OVF = 30;
  localparam int NMH_IRQ_DONE = 0;
  localparam int NMH_IRQ_OVF = 1;
  localparam int NMH_IRQ_W = 2;

  // ****************************************************************
  // Values
  // ****************************************************************
  localparam logic [31:0] NMH_SAT_MAX = 32'h7FFFFFFF;
  localparam logic [31:0] NMH_SAT_MIN = 32'h80000000;
  localparam logic [31:0] NMH_ZERO = 32'h00000000;
  localparam logic [1:0] NMH_IRQ_RST = 2'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic {
    NMH_CROSS = 1'b0,
    NMH_HIGH = 1'b1
  } nmh_variant_t;

  typedef struct packed {
    nmh_variant_t variant;
    logic sat;
    logic rec;
    logic oe;
  } nmh_op_t;

  typedef struct packed {
    logic lt;
    logic gt;
    logic eq;
    logic so;
  } nmh_cr_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } nmh_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } nmh_apb_rsp_t;

endpackage

//--- rtl/nmh_nmac_core.sv
// Combinational datapath: halfword product, negative accumulate, saturation
`timescale 1ns/1ps
`default_nettype none

module nmh_nmac_core
  import nmh_pkg::*;
(
  // Operands
  input wire logic [31:0] src_a_reg_i,
  input wire logic [31:0] src_b_reg_i,
  input wire logic [31:0] dest_i,
  input wire nmh_op_t op_i,
  // Results
  output logic [31:0] prod_o,
  output logic [32:0] sum_o,
  output logic [31:0] result_o,
  output logic ovf_o
);

  logic signed [15:0] half_a;
  logic signed [15:0] half_b;
  logic signed [31:0] prod;

  // ****************************************************************
  // Operand selection, big-endian bit 0 is the msb
  // ****************************************************************
  always_comb
  begin
    half_a = (op_i.variant == NMH_HIGH) ? src_a_reg_i[31:16] : src_a_reg_i[15:0];
    half_b = src_b_reg_i[31:16];
    prod = half_a * half_b;
  end

  // ****************************************************************
  // Subtract product; 33 bits so the overflow is visible
  // ****************************************************************
  always_comb
  begin
    prod_o = prod;
    sum_o = {dest_i[31], dest_i} - {prod[31], prod};
    ovf_o = sum_o[32] ^ sum_o[31];
    if (op_i.sat && ovf_o)
    begin
      result_o = sum_o[32] ? NMH_SAT_MIN : NMH_SAT_MAX;
    end
    else
    begin
      result_o = sum_o[31:0];
    end
  end

endmodule

`default_nettype wire

//--- rtl/nmh_unit.sv
// Top level: APB register file around the negative halfword MAC datapath
`timescale 1ns/1ps
`default_nettype none

module nmh_unit
  import nmh_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire nmh_apb_req_t apb_req_i,
  output nmh_apb_rsp_t apb_rsp_o,
  // Interrupt
  output logic irq_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [31:0] src_a_reg;
    logic [31:0] src_b_reg;
    logic [31:0] dest;
    nmh_op_t op;
    logic overflow_flag;
    logic so;
    nmh_cr_t condition_field_zero;
    logic [NMH_IRQ_W-1:0] irq_sts;
    logic [NMH_IRQ_W-1:0] irq_msk;
    logic [31:0] prdata;
  } nmh_state_t;

  localparam nmh_state_t NMH_STATE_RST = '0;

  nmh_state_t s_q;
  nmh_state_t s_d;

  logic wr_acc;
  logic rd_setup;
  logic acc;
  logic addr_hit;
  logic go;
  nmh_op_t op_w;
  logic [31:0] prod;
  logic [32:0] sum;
  logic [31:0] result;
  logic ovf;
  logic so_new;
  logic [NMH_IRQ_W-1:0] irq_set;
  logic [NMH_IRQ_W-1:0] irq_clr;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  always_comb
  begin
    acc = apb_req_i.psel && apb_req_i.penable;
    wr_acc = acc && apb_req_i.pwrite;
    rd_setup = apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite;
    case (apb_req_i.paddr)
      NMH_OFF_SRC_A, NMH_OFF_SRC_B, NMH_OFF_DEST, NMH_OFF_CTRL,
      NMH_OFF_EXC, NMH_OFF_COND, NMH_OFF_IRQ_STS, NMH_OFF_IRQ_MSK: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
    go = wr_acc && (apb_req_i.paddr == NMH_OFF_CTRL) && apb_req_i.pwdata[NMH_CTRL_GO];
  end

  // Operation fields come straight from the write so it runs in the same edge
  always_comb
  begin
    if (go)
    begin
      op_w.variant = nmh_variant_t'(apb_req_i.pwdata[NMH_CTRL_HIGH]);
      op_w.sat = apb_req_i.pwdata[NMH_CTRL_SAT];
      op_w.rec = apb_req_i.pwdata[NMH_CTRL_REC];
      op_w.oe = apb_req_i.pwdata[NMH_CTRL_OE];
    end
    else
    begin
      op_w = s_q.op;
    end
  end

  // ****************************************************************
  // Datapath
  // ****************************************************************
  nmh_nmac_core u_core (
    .src_a_reg_i(s_q.src_a_reg),
    .src_b_reg_i(s_q.src_b_reg),
    .dest_i(s_q.dest),
    .op_i(op_w),
    .prod_o(prod),
    .sum_o(sum),
    .result_o(result),
    .ovf_o(ovf)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_d = s_q;
    so_new = op_w.oe ? (s_q.so | ovf) : s_q.so;
    irq_set = '0;
    irq_clr = '0;

    // Register writes
    // Condition field is read-only: its writes fall to default and are dropped
    if (wr_acc)
    begin
      case (apb_req_i.paddr)
        NMH_OFF_SRC_A: s_d.src_a_reg = apb_req_i.pwdata;
        NMH_OFF_SRC_B: s_d.src_b_reg = apb_req_i.pwdata;
        NMH_OFF_DEST: s_d.dest = apb_req_i.pwdata;
        NMH_OFF_EXC:
        begin
          s_d.overflow_flag = apb_req_i.pwdata[NMH_EXC_OVF];
          s_d.so = apb_req_i.pwdata[NMH_EXC_SO];
        end
        NMH_OFF_IRQ_STS: irq_clr = apb_req_i.pwdata[NMH_IRQ_W-1:0];
        NMH_OFF_IRQ_MSK: s_d.irq_msk = apb_req_i.pwdata[NMH_IRQ_W-1:0];
        default: s_d.op = s_q.op;
      endcase
    end

    // Execute
    if (go)
    begin
      s_d.op = op_w;
      s_d.dest = result;
      if (op_w.oe)
      begin
        s_d.overflow_flag = ovf;
        s_d.so = so_new;
      end
      if (op_w.rec)
      begin
        s_d.condition_field_zero.lt = result[31];
        s_d.condition_field_zero.gt = !result[31] && (result != NMH_ZERO);
        s_d.condition_field_zero.eq = (result == NMH_ZERO);
        s_d.condition_field_zero.so = so_new;
      end
      irq_set[NMH_IRQ_DONE] = 1'b1;
      irq_set[NMH_IRQ_OVF] = ovf;
    end

    // Set beats a clear landing on the same edge
    s_d.irq_sts = (s_q.irq_sts & ~irq_clr) | irq_set;

    // Read data captured in the setup phase, master holds the address
    if (rd_setup)
    begin
      case (apb_req_i.paddr)
        NMH_OFF_SRC_A: s_d.prdata = s_q.src_a_reg;
        NMH_OFF_SRC_B: s_d.prdata = s_q.src_b_reg;
        NMH_OFF_DEST: s_d.prdata = s_q.dest;
        NMH_OFF_CTRL:
        begin
          s_d.prdata = NMH_ZERO;
          s_d.prdata[NMH_CTRL_HIGH] = s_q.op.variant;
          s_d.prdata[NMH_CTRL_SAT] = s_q.op.sat;
          s_d.prdata[NMH_CTRL_REC] = s_q.op.rec;
          s_d.prdata[NMH_CTRL_OE] = s_q.op.oe;
        end
        NMH_OFF_EXC:
        begin
          s_d.prdata = NMH_ZERO;
          s_d.prdata[NMH_EXC_OVF] = s_q.overflow_flag;
          s_d.prdata[NMH_EXC_SO] = s_q.so;
        end
        NMH_OFF_COND: s_d.prdata = {28'h0, s_q.condition_field_zero};
        NMH_OFF_IRQ_STS: s_d.prdata = {30'h0, s_q.irq_sts};
        NMH_OFF_IRQ_MSK: s_d.prdata = {30'h0, s_q.irq_msk};
        default: s_d.prdata = NMH_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_q <= NMH_STATE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Zero wait states: every access phase completes at its first edge
  always_comb
  begin
    apb_rsp_o.prdata = s_q.prdata;
    apb_rsp_o.pready = 1'b1;
    apb_rsp_o.pslverr = acc && !addr_hit;
    irq_o = |(s_q.irq_sts & s_q.irq_msk);
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  cross_product_a: assert property (
    go && (op_w.variant == NMH_CROSS) |->
      ($signed(prod) == $signed(s_q.src_a_reg[15:0]) * $signed(s_q.src_b_reg[31:16])))
    else $error("cross product operands wrong");

  high_product_a: assert property (
    go && (op_w.variant == NMH_HIGH) |->
      ($signed(prod) == $signed(s_q.src_a_reg[31:16]) * $signed(s_q.src_b_reg[31:16])))
    else $error("high product operands wrong");

  neg_sum_a: assert property (
    go |-> ($signed(sum) == $signed({s_q.dest[31], s_q.dest}) - $signed({prod[31], prod})))
    else $error("intermediate sum is not dest minus product");

  modulo_write_a: assert property (
    go && (!op_w.sat || !ovf) |=> (s_q.dest == $past(sum[31:0])))
    else $error("destination not low 32 bits of sum");

  sat_write_a: assert property (
    go && op_w.sat && ovf |=>
      (s_q.dest == ($past(sum[32]) ? NMH_SAT_MIN : NMH_SAT_MAX)))
    else $error("saturated value wrong");

  basic_keep_a: assert property (
    go && !op_w.rec && !op_w.oe |=>
      $stable(s_q.condition_field_zero) && $stable(s_q.overflow_flag) && $stable(s_q.so))
    else $error("basic form changed flags");

  record_only_a: assert property (
    go && op_w.rec && !op_w.oe |=>
      (s_q.condition_field_zero.eq == (s_q.dest == NMH_ZERO))
      && $stable(s_q.overflow_flag) && $stable(s_q.so))
    else $error("record form flags wrong");

  oe_only_a: assert property (
    go && op_w.oe && !op_w.rec |=>
      (s_q.overflow_flag == $past(ovf)) && (s_q.so == ($past(s_q.so) | $past(ovf)))
      && $stable(s_q.condition_field_zero))
    else $error("overflow-enable form flags wrong");

  oe_record_a: assert property (
    go && op_w.oe && op_w.rec |=>
      (s_q.overflow_flag == $past(ovf)) && (s_q.condition_field_zero.so == s_q.so)
      && (s_q.condition_field_zero.eq == (s_q.dest == NMH_ZERO)))
    else $error("combined form flags wrong");

  cr_sign_a: assert property (
    go && op_w.rec |=>
      (s_q.condition_field_zero.lt == s_q.dest[31])
      && (s_q.condition_field_zero.gt == (!s_q.dest[31] && (s_q.dest != NMH_ZERO)))
      && ($countones({s_q.condition_field_zero.lt, s_q.condition_field_zero.gt,
        s_q.condition_field_zero.eq}) == 1))
    else $error("condition field sign bits wrong");

  irq_set_a: assert property (
    go ##1 (s_q.irq_msk[NMH_IRQ_DONE]) |-> irq_o)
    else $error("done interrupt missing");

  ovf_irq_a: assert property (
    go && ovf |=> s_q.irq_sts[NMH_IRQ_OVF])
    else $error("overflow status bit not set");

  // A control write without start must not rerun the last operation
  ctrl_hold_a: assert property (
    wr_acc && (apb_req_i.paddr == NMH_OFF_CTRL) && !go |=>
      $stable(s_q.op) && $stable(s_q.dest))
    else $error("control write without start changed state");

  cond_ro_a: assert property (
    wr_acc && (apb_req_i.paddr == NMH_OFF_COND) |=> $stable(s_q.condition_field_zero))
    else $error("condition field took a bus write");

  bus_error_a: assert property (
    acc && !addr_hit |=>
      $stable(s_q.src_a_reg) && $stable(s_q.dest) && $stable(s_q.irq_msk))
    else $error("unmapped access changed state");

endmodule

`default_nettype wire

//--- testbench/nmh_apb_host.sv
// APB master model standing in for the bus master that drives the register file
`timescale 1ns/1ps
`default_nettype none

module nmh_apb_host
  import nmh_pkg::*;
(
  // Clock
  input wire logic ref_clk_i,
  // APB master side
  output nmh_apb_req_t apb_req_o,
  input wire nmh_apb_rsp_t apb_rsp_i
);
  logic [31:0] rdata;
  logic err;

  initial apb_req_o = '0;

  // ****************************************************************
  // One transfer
  // ****************************************************************
  // Request held until pready is seen; released lines show inverted data
  task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge ref_clk_i);
    apb_req_o <= '{1'b1, 1'b0, wr, adr, wd};
    @(posedge ref_clk_i);
    apb_req_o.penable <= 1'b1;
    do
      @(posedge ref_clk_i);
    while (apb_rsp_i.pready !== 1'b1);
    rdata = apb_rsp_i.prdata;
    err = apb_rsp_i.pslverr;
    apb_req_o <= '{1'b0, 1'b0, ~wr, ~adr, ~wd};
  endtask
endmodule

`default_nettype wire

//--- testbench/nmh_unit_tb.sv
// Self-checking bench for the negative halfword MAC unit
`timescale 1ns/1ps
`default_nettype none

module nmh_unit_tb
  import nmh_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  nmh_apb_req_t apb_req;
  nmh_apb_rsp_t apb_rsp;
  logic irq_o;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] exp_exc = '0;
  nmh_cr_t exp_cr = '0;
  // Operand sets: negative overflow, no overflow, positive overflow in the cross form only
  logic [31:0] va [3] = '{32'h12347FFF, 32'hFFFE8000, 32'h7FFF8000};
  logic [31:0] vb [3] = '{32'h7FFFABCD, 32'h80000003, 32'h7FFF5555};
  logic [31:0] vd [3] = '{32'h80000000, 32'h00000010, 32'h7FFFFFFF};

  always #12.5 ref_clk_i = ~ref_clk_i;

  nmh_unit nmh_unit_inst (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .apb_req_i(apb_req),
    .apb_rsp_o(apb_rsp),
    .irq_o(irq_o)
  );

  nmh_apb_host nmh_apb_host_inst (
    .ref_clk_i(ref_clk_i),
    .apb_req_o(apb_req),
    .apb_rsp_i(apb_rsp)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic stop_test;
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    nmh_apb_host_inst.xfer(1'b1, a, d);
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    nmh_apb_host_inst.xfer(1'b0, a, 32'h0);
    cmp(nmh_apb_host_inst.rdata, e);
  endtask

  // Irq is registered, so look half a cycle after the write lands
  task automatic chk_irq(input logic e);
    @(negedge ref_clk_i);
    cmp({31'h0, irq_o}, {31'h0, e});
  endtask

  // Mode bits m: {oe, rec, sat, high}
  task automatic run_op(input logic [31:0] a, b, d, input logic [3:0] m);
    logic signed [15:0] ha;
    logic signed [31:0] p;
    logic [32:0] s;
    logic ovf_bit;
    logic [31:0] r;
    ha = m[0] ? a[31:16] : a[15:0];
    p = ha * $signed(b[31:16]);
    s = {d[31], d} - {p[31], p};
    ovf_bit = s[32] ^ s[31];
    r = (m[1] && ovf_bit) ? (s[32] ? NMH_SAT_MIN : NMH_SAT_MAX) : s[31:0];
    if (m[3])
      exp_exc = {exp_exc[31] | ovf_bit, ovf_bit, 30'h0};
    if (m[2])
      exp_cr = '{$signed(r) < 0, $signed(r) > 0, r == 0, exp_exc[31]};
    wr(NMH_OFF_SRC_A, a);
    wr(NMH_OFF_SRC_B, b);
    wr(NMH_OFF_DEST, d);
    wr(NMH_OFF_CTRL, {27'h0, m, 1'b1});
    chk(NMH_OFF_DEST, r);
    chk(NMH_OFF_EXC, exp_exc);
    chk(NMH_OFF_COND, {28'h0, exp_cr});
    chk(NMH_OFF_IRQ_STS, {30'h0, ovf_bit, 1'b1});
    chk(NMH_OFF_CTRL, {27'h0, m, 1'b0});
    wr(NMH_OFF_IRQ_STS, 32'h3);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    for (int i = 0; i < 8; i++)
      chk(8'(i * 4), 32'h0);
    chk_irq(1'b0);
  endtask

  // Every form on every operand set; sticky summary cleared per set
  task automatic t_modes;
    for (int s = 0; s < 3; s++)
    begin
      wr(NMH_OFF_EXC, 32'h0);
      exp_exc = '0;
      for (int m = 0; m < 16; m++)
        run_op(va[s], vb[s], vd[s], 4'(m));
    end
  endtask

  // Zero operand first so only done fires, then a forced positive overflow
  task automatic t_irq;
    wr(NMH_OFF_IRQ_MSK, 32'h1);
    chk(NMH_OFF_IRQ_MSK, 32'h1);
    wr(NMH_OFF_SRC_A, 32'h0);
    wr(NMH_OFF_CTRL, 32'h1);
    chk_irq(1'b1);
    wr(NMH_OFF_IRQ_MSK, 32'h2);
    chk_irq(1'b0);
    wr(NMH_OFF_IRQ_MSK, 32'h1);
    wr(NMH_OFF_IRQ_STS, 32'h1);
    chk_irq(1'b0);
    wr(NMH_OFF_SRC_A, 32'h00008000);
    wr(NMH_OFF_SRC_B, 32'h7FFF0000);
    wr(NMH_OFF_DEST, 32'h7FFFFFFF);
    wr(NMH_OFF_CTRL, 32'h1);
    wr(NMH_OFF_IRQ_MSK, 32'h2);
    chk_irq(1'b1);
    wr(NMH_OFF_IRQ_STS, 32'h3);
    chk_irq(1'b0);
  endtask

  // Unmapped place errors, read-only condition field ignores writes
  task automatic t_bus;
    chk(8'h20, 32'h0);
    cmp({31'h0, nmh_apb_host_inst.err}, 32'h1);
    wr(NMH_OFF_COND, 32'hF);
    chk(NMH_OFF_COND, {28'h0, exp_cr});
    wr(NMH_OFF_CTRL, 32'h1E);
    chk(NMH_OFF_CTRL, 32'h0);
  endtask

  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      miscompares++;
      $display("unexpected at %0t: run too long", $time);
      stop_test();
    end
  end

  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_modes();
    t_irq();
    t_bus();
    stop_test();
  end
endmodule

`default_nettype wire
